/* design/system_integrity_monitor.sv */
/*
  System integrity monitor: undervoltage reset with hysteresis, voltage
  warning flag and interrupt, clock monitor with safe clock switching,
  and one 8-bit control/status register on an AHB-Lite slave.
  Assumes analog comparators, oscillator-loss detector and option bits
  arrive asynchronously; watchdog event, mask, halt, wait and service
  acknowledge come from logic on ref_clk. The clock tree performs the
  actual multiplexing from the two select outputs.
*/
// Design decisions made here: the AHB-Lite register port and the address map.
// Notes on behaviour
// - Undervoltage unit holds static reset while supply is below threshold.
// - Release above rising threshold, assert below falling threshold.
// - Unit presence and low, medium or high threshold come from options.
// - Reset pin is driven low while the undervoltage reset is active.
// - Real-time warning bit follows the comparator, read only, unlatched.
// - Warning detector is idle unless the undervoltage unit is enabled.
// - With its enable set, every warning flag toggle outside the reset and its delay requests an interrupt.
// - No warning interrupt for a crossing inside the reset delay.
// - Setting the enable while the flag is high requests one interrupt.
// - Glitch filtering runs only with the frequency-doubling PLL enabled.
// - On main clock loss the processor clock moves to the safe clock.
// - On main clock recovery it moves back without software.
// - Safe clock active sets the flag and requests an enabled interrupt.
// - Wait mode leaves all running; both interrupts wake from wait.
// - Halt freezes the register and disables the clock monitor.
// - Interrupt wake resumes configuration; reset wake restarts at reset.
// - Interrupt only with its enable set and the global mask cleared.
// - Neither event wakes from halt; both wake from wait.
// - Register resets to 000x 000x; bit 7 reads zero; bit 3 ignored.
// - Bit 6 enables warning interrupt; service entry clears its pending.
// - Bit 5 is the read-only warning flag, one means below threshold.
// - Bit 4 set by undervoltage reset, cleared by writing zero.
// - Bit 2 enables the clock interrupt; no effect with monitor off.
// - Bit 1 safe-clock flag; read clears after recovery; zero if off.
// - Bit 0 set by watchdog reset; cleared by zero write or undervoltage.
// - Undervoltage cause survives later external or watchdog resets.
`timescale 1ns/10ps
`default_nettype none
`include "sim_params.svh"

// ****************************************************************
// Three-stage synchroniser, accepts a change once stages agree
// ****************************************************************
module sim_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (clkEn) begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Output takes bits where the last two stages agree
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      syncOut <= '0;
    end else if (clkEn) begin
      syncOut <= (stage2 & stage3) | (syncOut & (stage2 | stage3));
    end
  end
endmodule

// ****************************************************************
// Top level
// ****************************************************************
module system_integrity_monitor
  import sim_pkg::*;
#(
  parameter int DELAY_SHORT = `SIM_DELAY_SHORT,
  parameter int DELAY_LONG = `SIM_DELAY_LONG,
  parameter int SWITCH_GAP = `SIM_SWITCH_GAP
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Asynchronous comparators, detector and options
  input wire logic supplyBelowRise,
  input wire logic supplyBelowFall,
  input wire logic warnCmpBelow,
  input wire logic mainClkLost,
  input wire logic optUvEnable,
  input wire logic [1:0] optLevel,
  input wire logic optLongDelay,
  input wire logic optClockMonEnable,
  input wire logic optPllEnable,
  // Same-clock system inputs
  input wire logic watchdogReset,
  input wire logic globalIrqMask,
  input wire logic haltMode,
  input wire logic waitMode,
  input wire logic warnIsrEnter,
  // Outputs
  output logic [1:0] thresholdSel,
  output logic coreResetHold,
  output logic resetPinOut,
  output logic resetPinOe,
  output logic warnIrq,
  output logic clockSecIrq,
  output logic wakeReq,
  output logic mainClkSel,
  output logic safeClkSel,
  output logic safeOscEnable,
  output logic glitchFilterEn
);
  localparam int CW = $clog2(DELAY_LONG + 1);
  localparam int GW = $clog2(SWITCH_GAP + 1);

  // Refuse settings the counters cannot serve
  if (DELAY_SHORT < 1 || DELAY_LONG < DELAY_SHORT ||
      SWITCH_GAP < 1) begin : g_bad_param
    $error("sim: bad delay or gap parameter");
  end

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [9:0] syncVec;
  logic belowRise;
  logic belowFall;
  logic warnBelow;
  logic clkLost;
  sim_opt_t opt;

  // Every asynchronous input passes the agreeing chain
  sim_sync #(.W(10)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .asyncIn({supplyBelowRise, supplyBelowFall, warnCmpBelow,
      mainClkLost, optUvEnable, optLevel, optLongDelay,
      optClockMonEnable, optPllEnable}),
    .syncOut(syncVec)
  );

  assign {belowRise, belowFall, warnBelow, clkLost} = syncVec[9:6];
  assign opt = sim_opt_t'(syncVec[5:0]);

  // ****************************************************************
  // Undervoltage reset and delay phase
  // ****************************************************************
  logic uvActive;
  logic [CW-1:0] delayCnt;
  logic rstHold;

  assign rstHold = uvActive || (delayCnt != '0);

  // Hysteresis: hold until above rising level, trip below falling
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      uvActive <= 1'b0;
    end else if (clkEn) begin
      if (!opt.uvEnable) begin
        uvActive <= 1'b0;
      end else if (uvActive) begin
        uvActive <= belowRise;
      end else begin
        uvActive <= belowFall;
      end
    end
  end

  // Reset delay after the supply recovers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      delayCnt <= '0;
    end else if (clkEn) begin
      if (uvActive) begin
        delayCnt <= opt.longDelay ? CW'(DELAY_LONG) : CW'(DELAY_SHORT);
      end else if (delayCnt != '0) begin
        delayCnt <= delayCnt - CW'(1);
      end
    end
  end

  // Reset pin pulled low during reset and delay
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      coreResetHold <= 1'b0;
      resetPinOut <= 1'b0;
      resetPinOe <= 1'b0;
      thresholdSel <= 2'h0;
    end else if (clkEn) begin
      coreResetHold <= rstHold;
      resetPinOut <= 1'b0;
      resetPinOe <= rstHold;
      thresholdSel <= (opt.level == 2'h3) ? 2'h2 : opt.level;
    end
  end

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic wrPend;
  logic addrHit;
  logic rdHit;
  logic wrBit6;
  logic wrStrobe;
  logic [7:0] csrView;
  logic warnIe;
  logic warnFlag;
  logic uvCause;
  logic csIe;
  logic safeFlag;
  logic wdgCause;

  assign addrHit = hsel && htrans[1] && hready &&
    (haddr == `SIM_CSR_ADDR);
  assign rdHit = addrHit && !hwrite;
  assign wrStrobe = wrPend && !haltMode;
  assign wrBit6 = hwdata[`SIM_BIT_WARN_IE];

  // Bit 7 and bit 3 read zero
  always_comb begin
    csrView = 8'h00;
    csrView[`SIM_BIT_WARN_IE] = warnIe;
    csrView[`SIM_BIT_WARN_FLAG] = warnFlag;
    csrView[`SIM_BIT_UV_CAUSE] = uvCause;
    csrView[`SIM_BIT_CS_IE] = csIe;
    csrView[`SIM_BIT_SAFE_FLAG] = safeFlag;
    csrView[`SIM_BIT_WDG_CAUSE] = wdgCause;
  end

  // Zero wait states, always OKAY, unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wrPend <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clkEn) begin
      wrPend <= addrHit && hwrite;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rdHit) begin
        hrdata <= {24'h00_0000, csrView};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Enable bits
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      warnIe <= `SIM_IE_RESET;
      csIe <= `SIM_IE_RESET;
    end else if (clkEn && wrStrobe) begin
      warnIe <= wrBit6;
      csIe <= hwdata[`SIM_BIT_CS_IE];
    end
  end

  // ****************************************************************
  // Reset cause flags, no fixed reset value
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (uvActive) begin
        uvCause <= 1'b1;
      end else if (wrStrobe && !hwdata[`SIM_BIT_UV_CAUSE]) begin
        uvCause <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (uvActive) begin
        wdgCause <= 1'b0;
      end else if (watchdogReset) begin
        wdgCause <= 1'b1;
      end else if (wrStrobe && !hwdata[`SIM_BIT_WDG_CAUSE]) begin
        wdgCause <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Voltage warning detector
  // ****************************************************************
  logic warnPend;
  logic warnToggle;
  logic warnEnRise;
  logic warnSet;

  // Flag follows comparator live, idle without the unit, held in halt
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      warnFlag <= 1'b0;
    end else if (clkEn && !haltMode) begin
      warnFlag <= opt.uvEnable && warnBelow;
    end
  end

  logic warnPrev;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      warnPrev <= 1'b0;
    end else if (clkEn) begin
      warnPrev <= warnFlag;
    end
  end

  assign warnToggle = (warnFlag != warnPrev) && !rstHold;
  assign warnEnRise = wrStrobe && wrBit6 && !warnIe && warnFlag;
  assign warnSet = opt.uvEnable &&
    ((warnIe && warnToggle) || warnEnRise);

  // Pending request; a new event wins over the service clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      warnPend <= 1'b0;
    end else if (clkEn) begin
      if (warnSet) begin
        warnPend <= 1'b1;
      end else if (warnIsrEnter || !warnIe) begin
        warnPend <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Clock monitor and source switch
  // ****************************************************************
  sim_ck_state_t ckState;
  logic [GW-1:0] gapCnt;
  logic monOn;

  assign monOn = opt.clockMonEnable && !haltMode;

  // Break before make between sources, gap counted on ref_clk
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ckState <= SIM_CK_MAIN;
      gapCnt <= '0;
    end else if (clkEn && !haltMode) begin
      unique case (ckState)
        SIM_CK_MAIN: begin
          if (opt.clockMonEnable && clkLost) begin
            ckState <= SIM_CK_TO_SAFE;
            gapCnt <= GW'(SWITCH_GAP);
          end
        end
        SIM_CK_TO_SAFE: begin
          if (gapCnt != '0) begin
            gapCnt <= gapCnt - GW'(1);
          end else begin
            ckState <= SIM_CK_SAFE;
          end
        end
        SIM_CK_SAFE: begin
          if (!clkLost || !opt.clockMonEnable) begin
            ckState <= SIM_CK_TO_MAIN;
            gapCnt <= GW'(SWITCH_GAP);
          end
        end
        SIM_CK_TO_MAIN: begin
          if (gapCnt != '0) begin
            gapCnt <= gapCnt - GW'(1);
          end else begin
            ckState <= SIM_CK_MAIN;
          end
        end
        default: begin
          ckState <= SIM_CK_MAIN;
        end
      endcase
    end
  end

  // Select outputs never overlap
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mainClkSel <= 1'b1;
      safeClkSel <= 1'b0;
      safeOscEnable <= 1'b0;
      glitchFilterEn <= 1'b0;
    end else if (clkEn) begin
      mainClkSel <= (ckState == SIM_CK_MAIN);
      safeClkSel <= (ckState == SIM_CK_SAFE);
      safeOscEnable <= monOn;
      glitchFilterEn <= opt.pllEnable;
    end
  end

  // Safe-clock flag; setting wins over the read clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      safeFlag <= 1'b0;
    end else if (clkEn) begin
      if (!opt.clockMonEnable) begin
        safeFlag <= 1'b0;
      end else if (haltMode) begin
        safeFlag <= safeFlag;
      end else if (ckState == SIM_CK_SAFE) begin
        safeFlag <= 1'b1;
      end else if (rdHit && !clkLost) begin
        safeFlag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupt requests and wake-up
  // ****************************************************************
  logic csReq;
  logic warnReq;

  assign csReq = safeFlag && csIe && opt.clockMonEnable;
  assign warnReq = warnPend;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      warnIrq <= 1'b0;
      clockSecIrq <= 1'b0;
      wakeReq <= 1'b0;
    end else if (clkEn) begin
      warnIrq <= warnReq && !globalIrqMask;
      clockSecIrq <= csReq && !globalIrqMask;
      wakeReq <= waitMode && !haltMode &&
        (warnReq || csReq);
    end
  end
endmodule

`default_nettype wire

/* design/sim_params.svh */
/*
  Constants of the system integrity monitor: register place, field
  positions, reset values and timing counts.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef SIM_PARAMS_SVH
`define SIM_PARAMS_SVH

// ****************************************************************
// Register place
// ****************************************************************
`define SIM_CSR_INDEX 8'h25
`define SIM_CSR_ADDR 32'h0000_0094

// ****************************************************************
// Field positions of the control/status register
// ****************************************************************
`define SIM_BIT_WARN_IE 6
`define SIM_BIT_WARN_FLAG 5
`define SIM_BIT_UV_CAUSE 4
`define SIM_BIT_CS_IE 2
`define SIM_BIT_SAFE_FLAG 1
`define SIM_BIT_WDG_CAUSE 0

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define SIM_IE_RESET 1'b0
`define SIM_DELAY_SHORT 256
`define SIM_DELAY_LONG 4096
`define SIM_SWITCH_GAP 4

`endif

/* design/sim_pkg.sv */
/*
  Types of the system integrity monitor.
  Assumes the constants header is on the include path.
*/
package sim_pkg;
  `include "sim_params.svh"

  // Option-byte settings after synchronisation
  typedef struct packed {
    logic uvEnable;
    logic [1:0] level;
    logic longDelay;
    logic clockMonEnable;
    logic pllEnable;
  } sim_opt_t;

  // Clock source selection states
  typedef enum logic [3:0] {
    SIM_CK_MAIN = 4'h1,
    SIM_CK_TO_SAFE = 4'h2,
    SIM_CK_SAFE = 4'h4,
    SIM_CK_TO_MAIN = 4'h8
  } sim_ck_state_t;
endpackage

/* test/sim_checker.sv */
/*
  Port checker of the system integrity monitor.
  Assumes it is bound onto the top module; one clock, ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Checker
// ****************************************************************
module sim_checker #(
  parameter int DELAY_SHORT = 4,
  parameter int DELAY_LONG = 8,
  parameter int SWITCH_GAP = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic supplyBelowFall,
  input wire logic mainClkLost,
  input wire logic optClockMonEnable,
  input wire logic globalIrqMask,
  input wire logic haltMode,
  input wire logic coreResetHold,
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic warnIrq,
  input wire logic clockSecIrq,
  input wire logic wakeReq,
  input wire logic mainClkSel,
  input wire logic safeClkSel,
  input wire logic safeOscEnable
);
  int holdLen;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // Length of the running reset hold
  always_ff @(posedge ref_clk) begin
    if (!nrst || !coreResetHold) begin
      holdLen <= 0;
    end else begin
      holdLen <= holdLen + 1;
    end
  end

  // Reset, pin and bus data
  a_pin_mirror: assert property (resetPinOe == coreResetHold && !resetPinOut)
    else $error("reset pin does not follow the hold");
  a_trip_cause: assert property ($rose(coreResetHold) |->
    $past(supplyBelowFall, 3) || $past(supplyBelowFall, 4))
    else $error("hold rose without low supply");
  a_hold_length: assert property ($fell(coreResetHold) |->
    holdLen >= DELAY_SHORT)
    else $error("hold released before the delay");
  a_read_quiet: assert property (!$past(hsel && htrans[1] && hready &&
    !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside a read");
  a_top_bits: assert property (hrdata[31:7] == 25'h0)
    else $error("reserved bits read nonzero");

  // Clock selection
  a_sel_exclusive: assert property (!(mainClkSel && safeClkSel))
    else $error("both clock selects high");
  a_switch_gap: assert property ($fell(mainClkSel) |-> !safeClkSel [*2])
    else $error("no dead gap on switching");
  a_loss_switch: assert property ($rose(mainClkLost) && optClockMonEnable
    |-> ##[1:20] (safeClkSel || !mainClkLost || haltMode))
    else $error("no switch to safe clock");
  a_recover_back: assert property ($fell(mainClkLost) |->
    ##[1:30] (mainClkSel || mainClkLost || haltMode))
    else $error("no switch back to main clock");

  // Interrupts and low power
  a_masked_quiet: assert property (globalIrqMask && $past(globalIrqMask)
    |-> !warnIrq && !clockSecIrq)
    else $error("interrupt while masked");
  a_halt_no_wake: assert property (haltMode && $past(haltMode) |-> !wakeReq)
    else $error("wake request in halt");
  a_halt_osc_off: assert property (haltMode && $past(haltMode)
    |-> !safeOscEnable)
    else $error("safe oscillator on in halt");
endmodule
`default_nettype wire

/* test/sim_core_model.sv */
/*
  Core and interrupt controller model: enters the warning service
  routine after a short or long latency.
  Assumes ref_clk and nrst are shared with the monitor.
*/
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Core model
// ****************************************************************
module sim_core_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic warnIrq,
  input wire logic ackSlow,
  output logic warnIsrEnter,
  output int taken
);
  int cnt;
  int lat;

  assign lat = ackSlow ? 6 : 1;

  // Service entry, then a settle gap while the request drops
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt <= 0;
      warnIsrEnter <= 1'h0;
      taken <= 0;
    end else begin
      warnIsrEnter <= 1'h0;
      if (cnt == 0) begin
        cnt <= (warnIrq === 1'h1) ? 1 : 0;
      end else if (cnt == lat) begin
        warnIsrEnter <= 1'h1;
        taken <= taken + 1;
        cnt <= cnt + 1;
      end else begin
        cnt <= (cnt >= lat + 3) ? 0 : cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* test/test_system_integrity_monitor.sv */
/*
  Self-checking bench of the system integrity monitor.
  Assumes the design, its header, the core model and the checker.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sim_params.svh"

module test_system_integrity_monitor;
  localparam int DS = 4;
  localparam int DL = 32;
  localparam logic [31:0] CSR = `SIM_CSR_ADDR;
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] wd;
    logic [7:0] rd;
  } sim_row_t;
  // Register writes and the read-back each should give
  sim_row_t rows [5] = '{'{CSR, 8'hFF, 8'h55}, '{32'h90, 8'h00, 8'h00},
    '{CSR, 8'hEE, 8'h44}, '{CSR, 8'h08, 8'h00}, '{CSR, 8'h04, 8'h04}};
  logic [1:0] lvlExp [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  int dly [2] = '{DS, DL};
  int mismatches = 0, checks = 0, n, taken;
  logic ref_clk = 1'h0, nrst = 1'h0, clkEn = 1'h1, hsel = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0, optLevel = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hwrite = 1'h0, supplyBelowRise = 1'h0, supplyBelowFall = 1'h0;
  logic warnCmpBelow = 1'h0, mainClkLost = 1'h0, optUvEnable = 1'h0;
  logic optLongDelay = 1'h0, optClockMonEnable = 1'h0, optPllEnable = 1'h0;
  logic watchdogReset = 1'h0, globalIrqMask = 1'h0, haltMode = 1'h0;
  logic waitMode = 1'h0, ackSlow = 1'h0;
  logic [7:0] rv;
  wire logic hready, hreadyout, hresp, warnIsrEnter, coreResetHold;
  wire logic resetPinOut, resetPinOe, warnIrq, clockSecIrq, wakeReq;
  wire logic mainClkSel, safeClkSel, safeOscEnable, glitchFilterEn;
  wire logic [1:0] thresholdSel;
  wire logic [31:0] hrdata;
  wire logic [3:0] watch;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  assign watch = {wakeReq, safeClkSel, mainClkSel, coreResetHold};

  system_integrity_monitor #(.DELAY_SHORT(DS), .DELAY_LONG(DL),
    .SWITCH_GAP(2)) dut_u (.ref_clk, .nrst, .clkEn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata,
    .hresp, .supplyBelowRise, .supplyBelowFall, .warnCmpBelow,
    .mainClkLost, .optUvEnable, .optLevel, .optLongDelay,
    .optClockMonEnable, .optPllEnable, .watchdogReset, .globalIrqMask,
    .haltMode, .waitMode, .warnIsrEnter, .thresholdSel, .coreResetHold,
    .resetPinOut, .resetPinOe, .warnIrq, .clockSecIrq, .wakeReq,
    .mainClkSel, .safeClkSel, .safeOscEnable, .glitchFilterEn);
  sim_core_model core_u (.ref_clk, .nrst, .warnIrq, .ackSlow,
    .warnIsrEnter, .taken);

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // One AHB-Lite single transfer; read data lands in rv
  task automatic bus(input logic w, input logic [31:0] a,
      input logic [7:0] d);
    @(posedge ref_clk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hready !== 1'h1);
    rv = hrdata[7:0];
  endtask

  task automatic rd();
    bus(1'h0, CSR, 8'h00);
  endtask

  task automatic wr(input logic [7:0] d);
    bus(1'h1, CSR, d);
  endtask

  // Bounded wait for one watched output to reach a level
  task automatic waitFor(input int i, input logic v, input string what);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (watch[i] !== v && n < 64);
    chk(32'(watch[i] === v), 32'h1, what);
  endtask

  task automatic afterReset();
    nrst <= 1'h0;
    step(16);
    nrst <= 1'h1;
    rd();
    chk(rv & 8'hEE, 8'h00, "register after reset");
    chk({mainClkSel, safeClkSel, warnIrq}, 3'h4, "outputs after reset");
  endtask

  task automatic close_out();
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  initial begin
    afterReset();
    for (int i = 0; i < 4; i++) begin
      optLevel <= 2'(i);
      step(6);
      chk(thresholdSel, lvlExp[i], "threshold select");
    end
    supplyBelowFall <= 1'h1;
    step(12);
    chk(coreResetHold, 1'h0, "unit disabled");
    optUvEnable <= 1'h1;
    for (int d = 0; d < 2; d++) begin
      optLongDelay <= 1'(d);
      supplyBelowRise <= 1'h1;
      supplyBelowFall <= 1'h1;
      waitFor(0, 1'h1, "undervoltage trip");
      chk({resetPinOe, resetPinOut}, 2'h2, "reset pin low");
      supplyBelowFall <= 1'h0;
      step(10);
      chk(coreResetHold, 1'h1, "hysteresis hold");
      supplyBelowRise <= 1'h0;
      waitFor(0, 1'h0, "undervoltage release");
      chk(32'(n >= dly[d] && n <= dly[d] + 8), 32'h1, "delay");
    end
    rd();
    chk(rv & 8'h11, 8'h10, "cause after undervoltage");
    watchdogReset <= 1'h1;
    step(1);
    watchdogReset <= 1'h0;
    rd();
    chk(rv & 8'h11, 8'h11, "cause kept by watchdog");
    foreach (rows[i]) begin
      bus(1'h1, rows[i].addr, rows[i].wd);
      bus(1'h0, rows[i].addr, 8'h00);
      chk(rv, rows[i].rd, "register row");
      chk({hresp, hreadyout}, 2'h1, "bus answer");
    end
    warnCmpBelow <= 1'h1;
    step(8);
    rd();
    chk(rv & 8'h60, 8'h20, "warning flag set");
    chk(taken, 0, "no irq while disabled");
    wr(8'h44);
    step(16);
    chk(taken, 1, "irq on enable");
    globalIrqMask <= 1'h1;
    waitMode <= 1'h1;
    warnCmpBelow <= 1'h0;
    step(16);
    chk(taken, 1, "masked toggle");
    rd();
    chk(rv & 8'h20, 8'h00, "flag follows comparator");
    ackSlow <= 1'h1;
    globalIrqMask <= 1'h0;
    waitFor(3, 1'h1, "wake from wait");
    step(16);
    chk(taken, 2, "irq on rising crossing");
    chk(warnIrq, 1'h0, "pending cleared");
    waitMode <= 1'h0;
    optClockMonEnable <= 1'h1;
    step(6);
    mainClkLost <= 1'h1;
    waitFor(2, 1'h1, "switch to safe");
    step(2);
    chk({mainClkSel, clockSecIrq, safeOscEnable}, 3'h3, "safe state");
    rd();
    chk(rv & 8'h06, 8'h06, "safe flag set");
    haltMode <= 1'h1;
    step(4);
    chk(safeOscEnable, 1'h0, "oscillator off in halt");
    wr(8'h00);
    haltMode <= 1'h0;
    rd();
    chk({safeClkSel, rv[2]}, 2'h3, "resumed after halt");
    mainClkLost <= 1'h0;
    waitFor(1, 1'h1, "switch back");
    rd();
    chk(rv & 8'h02, 8'h02, "flag held until read");
    rd();
    chk(rv & 8'h02, 8'h00, "flag cleared by read");
    optClockMonEnable <= 1'h0;
    mainClkLost <= 1'h1;
    step(24);
    chk({safeClkSel, clockSecIrq}, 2'h0, "monitor off");
    rd();
    chk(rv & 8'h02, 8'h00, "safe flag forced low");
    mainClkLost <= 1'h0;
    optPllEnable <= 1'h1;
    clkEn <= 1'h0;
    step(8);
    chk(glitchFilterEn, 1'h0, "frozen by enable");
    clkEn <= 1'h1;
    step(8);
    chk(glitchFilterEn, 1'h1, "filter with pll");
    optPllEnable <= 1'h0;
    step(8);
    chk(glitchFilterEn, 1'h0, "filter without pll");
    optUvEnable <= 1'h0;
    warnCmpBelow <= 1'h1;
    step(12);
    rd();
    chk(rv & 8'h20, 8'h00, "warning idle");
    chk(taken, 2, "no irq when idle");
    afterReset();
    close_out();
  end
endmodule

bind system_integrity_monitor sim_checker #(.DELAY_SHORT(DELAY_SHORT),
  .DELAY_LONG(DELAY_LONG), .SWITCH_GAP(SWITCH_GAP)) chk_u (.ref_clk,
  .nrst, .hsel, .htrans, .hwrite, .hready, .hrdata, .supplyBelowFall,
  .mainClkLost, .optClockMonEnable, .globalIrqMask, .haltMode,
  .coreResetHold, .resetPinOut, .resetPinOe, .warnIrq, .clockSecIrq,
  .wakeReq, .mainClkSel, .safeClkSel, .safeOscEnable);
`default_nettype wire
